// [core/ttd_cfg.svh]
`ifndef TTD_CFG_SVH
`define TTD_CFG_SVH
`define TTD_OFS_ID_LAST   8'h1F
`define TTD_OFS_CTRL      8'h24
`define TTD_OFS_STAT      8'h26
`define TTD_IO_LAST       8'h27
`define TTD_CTRL_RST      16'h0000
`define TTD_CTRL_MASK     16'hCFFF
`define TTD_SEL_HI        15
`define TTD_SEL_LO        14
`define TTD_CODE_HI       11
`define TTD_BUSY_BIT      0
`define TTD_ID_WORDS      32
`define TTD_CNV_NS        1000
`define TTD_CLK_NS        5
`define TTD_CNV_CYC       ((`TTD_CNV_NS + `TTD_CLK_NS - 1) / `TTD_CLK_NS)
`endif

// [core/ttd_pkg.sv]
`default_nettype none
package ttd_pkg;
  typedef enum logic [1:0] {
    TTD_CH_MOD_ONE, TTD_CH_MOD_TWO, TTD_CH_DIFF_ONE, TTD_CH_DIFF_TWO
  } ttd_chan_t;
  typedef enum {TTD_IDLE, TTD_STROBE, TTD_ACK} ttd_bus_t;
endpackage
`default_nettype wire

// [core/ttd_regs.sv]
`include "ttd_cfg.svh"
`default_nettype none
module ttd_regs
  import ttd_pkg::*;
#(
  parameter logic [15:0] ID_WORD  = 16'h0A5C, // Arbitrary identity value.
  parameter int          CNV_CYC  = `TTD_CNV_CYC
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Mezzanine bus pins, strobes and dtack_n active low.
  input  wire logic        cs_n,
  input  wire logic        ds0_n,
  input  wire logic        ds1_n,
  input  wire logic        write_n,
  input  wire logic [7:1]  addr,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic             data_oe,
  output logic             dtack_n,
  // Converter side.
  output logic      [11:0] dac_code,
  output ttd_pkg::ttd_chan_t dac_chan,
  output logic             dac_load
);
  import ttd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [11:0] s1_q, s2_q;
  logic [15:0] dsyn1_q, dsyn2_q;
  always_ff @(posedge clk_sys) begin
    s1_q    <= {cs_n, ds0_n, ds1_n, write_n, addr, 1'b0};
    s2_q    <= s1_q;
    dsyn1_q <= data_in;
    dsyn2_q <= dsyn1_q;
  end
  logic       strobe;
  logic       wr;
  logic [7:0] badr;
  assign strobe = ~s2_q[11] & (~s2_q[10] | ~s2_q[9]);
  assign wr     = ~s2_q[8];
  assign badr   = s2_q[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Identity memory, constant contents.
  logic [15:0] id_rom [`TTD_ID_WORDS];
  always_comb begin
    for (int i = 0; i < `TTD_ID_WORDS; i++) begin
      id_rom[i] = 16'h0000;
    end
    id_rom[0] = ID_WORD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle, registers and converter timer.
  ttd_bus_t    st_q, st_d;
  logic [15:0] ctrl_q, ctrl_d, rd_q, rd_d;
  logic [31:0] cnt_q, cnt_d;
  logic        load_q, load_d;
  logic        busy;
  assign busy = (cnt_q != 32'h0000_0000);

  always_comb begin
    st_d   = st_q;
    ctrl_d = ctrl_q;
    rd_d   = rd_q;
    cnt_d  = busy ? cnt_q - 32'h0000_0001 : cnt_q;
    load_d = 1'b0;
    case (st_q)
      TTD_IDLE: begin
        if (strobe) begin
          st_d = TTD_STROBE;
        end
      end
      TTD_STROBE: begin
        if (!strobe) begin
          st_d = TTD_IDLE;
        end else begin
          st_d = TTD_ACK;
          rd_d = 16'h0000;
          if (badr <= `TTD_OFS_ID_LAST) begin
            rd_d = id_rom[badr[5:1]];
          end else if (badr == `TTD_OFS_CTRL) begin
            rd_d = ctrl_q;
            if (wr) begin
              ctrl_d = dsyn2_q & `TTD_CTRL_MASK;
              cnt_d  = 32'(CNV_CYC);
              load_d = 1'b1;
            end
          end else if (badr == `TTD_OFS_STAT) begin
            rd_d[`TTD_BUSY_BIT] = busy;
          end
        end
      end
      TTD_ACK: begin
        if (!strobe) begin
          st_d = TTD_IDLE;
        end
      end
      default: st_d = TTD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q   <= TTD_IDLE;
      ctrl_q <= `TTD_CTRL_RST;
      rd_q   <= 16'h0000;
      cnt_q  <= 32'h0000_0000;
      load_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      ctrl_q <= ctrl_d;
      rd_q   <= rd_d;
      cnt_q  <= cnt_d;
      load_q <= load_d;
    end
  end

  assign data_out = rd_q;
  assign data_oe  = (st_q == TTD_ACK) & ~wr;
  assign dtack_n  = ~(st_q == TTD_ACK);
  assign dac_code = ctrl_q[`TTD_CODE_HI:0];
  assign dac_chan = ttd_chan_t'(ctrl_q[`TTD_SEL_HI:`TTD_SEL_LO]);
  assign dac_load = load_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus steps that the checks are built from.
  sequence s_take_any;
    st_q == TTD_STROBE && strobe;
  endsequence

  sequence s_take_ctrl_write;
    st_q == TTD_STROBE && strobe && wr && badr == `TTD_OFS_CTRL;
  endsequence

  sequence s_take_other_write;
    st_q == TTD_STROBE && strobe && wr && badr != `TTD_OFS_CTRL;
  endsequence

  sequence s_take_unmapped;
    st_q == TTD_STROBE && strobe && badr > `TTD_IO_LAST;
  endsequence

  sequence s_ack_released;
    !dtack_n && !strobe;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_reset_clear;
    @(posedge clk_sys) reset |=> (dac_code == 12'h000 && !dac_load);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset");

  property p_busy_after_load;
    @(posedge clk_sys) disable iff (reset) dac_load |-> busy;
  endproperty
  a_busy_after_load: assert property (p_busy_after_load)
    else $error("busy not set");

  property p_id_const;
    @(posedge clk_sys) disable iff (reset)
      (st_q == TTD_STROBE && strobe && badr == 8'h00) |=> rd_q == ID_WORD;
  endproperty
  a_id_const: assert property (p_id_const) else $error("id word");

  property p_ack_holds;
    @(posedge clk_sys) disable iff (reset)
      (!dtack_n && strobe) |=> !dtack_n;
  endproperty
  a_ack_holds: assert property (p_ack_holds) else $error("ack drop");

  property p_code_follow;
    @(posedge clk_sys) disable iff (reset)
      s_take_ctrl_write |=> dac_code == $past(dsyn2_q[`TTD_CODE_HI:0]);
  endproperty
  a_code_follow: assert property (p_code_follow) else $error("code");

  property p_chan_follow;
    @(posedge clk_sys) disable iff (reset)
      s_take_ctrl_write
      |=> dac_chan == ttd_chan_t'($past(dsyn2_q[`TTD_SEL_HI:`TTD_SEL_LO]));
  endproperty
  a_chan_follow: assert property (p_chan_follow) else $error("chan");

  property p_load_pulse;
    @(posedge clk_sys) disable iff (reset)
      s_take_ctrl_write |=> dac_load ##1 !dac_load;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load");

  property p_other_write_kept;
    @(posedge clk_sys) disable iff (reset)
      s_take_other_write |=> $stable(ctrl_q);
  endproperty
  a_other_write_kept: assert property (p_other_write_kept)
    else $error("ctrl changed");

  property p_unmapped_zero;
    @(posedge clk_sys) disable iff (reset)
      s_take_unmapped |=> rd_q == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read");

  property p_ack_answer;
    @(posedge clk_sys) disable iff (reset)
      s_take_any |=> !dtack_n;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack");

  property p_ack_release;
    @(posedge clk_sys) disable iff (reset)
      s_ack_released |=> dtack_n;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("ack stuck");
endmodule
`default_nettype wire

// [verif/ttd_host.sv]
`default_nettype none
module ttd_host (
  // Clock.
  input  wire logic        clk_sys,
  // Bus pins.
  output logic             cs_n,
  output logic             ds0_n,
  output logic             ds1_n,
  output logic             write_n,
  output logic      [7:1]  addr,
  output logic      [15:0] data_in,
  input  wire logic [15:0] data_out,
  input  wire logic        dtack_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Counts waits that ran out without an answer.
  int timeouts = 0;
  initial {cs_n, ds0_n, ds1_n, write_n, addr, data_in} = '1;
  // Runs one full word cycle at an even address.
  task automatic cyc(input logic wr, input logic [7:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk_sys);
    {cs_n, ds0_n, ds1_n, write_n} <= {3'b000, !wr};
    addr <= a[7:1];
    data_in <= d;
    for (n = 0; n < 20 && dtack_n !== 1'b0; n++) @(posedge clk_sys);
    if (n == 20) timeouts++;
    q = data_out;
    {cs_n, ds0_n, ds1_n} <= 3'b111;
    data_in <= ~d;
    for (n = 0; n < 20 && dtack_n !== 1'b1; n++) @(posedge clk_sys);
    if (n == 20) timeouts++;
  endtask
endmodule
`default_nettype wire

// [verif/ttd_regs_bench.sv]
`include "ttd_cfg.svh"
`default_nettype none
module ttd_regs_bench;
  import ttd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] IDW = 16'h0A5C; // Arbitrary identity value.
  logic clk_sys = 0, reset = 1, cs_n, ds0_n, ds1_n, write_n, data_oe;
  logic dtack_n, dac_load;
  logic [7:1] addr;
  logic [15:0] data_in, data_out, q;
  logic [11:0] dac_code;
  ttd_chan_t dac_chan;
  logic [15:0] exp_q[$], exp_load;
  int num_errors = 0, total_checks = 0, loads = 0, ctrl = 0, c, k;
  always #2.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
    if (dac_load === 1'b1) begin
      loads <= loads + 1;
      exp_load = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFFFF;
      chk("load", exp_load, {dac_chan, 2'b00, dac_code});
    end
  always @(negedge clk_sys)
    if (!reset)
      chk("oe", {15'h0, !dtack_n && write_n}, {15'h0, data_oe});
  ttd_regs #(.ID_WORD(IDW), .CNV_CYC(20)) dut (.clk_sys(clk_sys),
    .reset(reset), .cs_n(cs_n), .ds0_n(ds0_n), .ds1_n(ds1_n),
    .write_n(write_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .dtack_n(dtack_n),
    .dac_code(dac_code), .dac_chan(dac_chan), .dac_load(dac_load));
  ttd_host host (.clk_sys(clk_sys), .cs_n(cs_n), .ds0_n(ds0_n),
    .ds1_n(ds1_n), .write_n(write_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .dtack_n(dtack_n));
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(14));
    repeat (10) @(posedge clk_sys);
    reset <= 0;
    host.cyc(0, `TTD_OFS_CTRL, 0, q);
    chk("ctrl", 0, q);
    for (k = 0; 2 * k <= `TTD_OFS_ID_LAST; k++) begin
      host.cyc(1, 8'(2 * k), 16'hFFFF, q);
      host.cyc(0, 8'(2 * k), 0, q);
      chk("id", k ? 16'h0 : IDW, q);
    end
    host.cyc(0, 8'h28, 0, q);
    chk("unmapped", 0, q);
    for (k = 0; k < 8; k++) begin
      c = ($urandom & 32'h3FFF) | ((k % 4) << 14);
      if (k == 4) c = c & 32'hF000;
      if (k == 7) c = c | 32'h0FFF;
      ctrl = c & 32'hCFFF;
      exp_q.push_back(16'(ctrl));
      host.cyc(1, `TTD_OFS_CTRL, c[15:0], q);
      chk("code", 16'(ctrl & 32'hFFF), {4'h0, dac_code});
      chk("chan", 16'(ctrl >> 14), {14'h0, dac_chan});
      host.cyc(0, `TTD_OFS_STAT, 0, q);
      chk("busy", 1, {15'h0, q[0]});
      for (c = 0; c < 20 && q[0] !== 1'b0; c++)
        host.cyc(0, `TTD_OFS_STAT, 0, q);
      chk("idle", 0, {15'h0, q[0]});
      host.cyc(0, `TTD_OFS_CTRL, 0, q);
      chk("ctrl", 16'(ctrl), q);
    end
    exp_q.push_back(16'h8123);
    host.cyc(1, `TTD_OFS_CTRL, 16'h8123, q);
    reset <= 1'b1;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    chk("code after reset", 0, {4'h0, dac_code});
    host.cyc(0, `TTD_OFS_CTRL, 0, q);
    chk("ctrl after reset", 0, q);
    host.cyc(0, `TTD_OFS_STAT, 0, q);
    chk("busy after reset", 0, {15'h0, q[0]});
    chk("loads", 9, 16'(loads));
    chk("timeouts", 0, 16'(host.timeouts));
    complete_run();
  end
endmodule
`default_nettype wire
